// file: rtl/dia_pkg.sv
`default_nettype none

package dia_pkg;
  // Timing base
  localparam int unsigned CLK_HZ = 10_000_000;
  // Default sizes
  localparam int NCH_DEF = 16;
  localparam int PORT_W = 8;
  localparam int FIFO_DEPTH_DEF = 512;
  localparam int FDW_DEF = 20;
  localparam int CW_DEF = 16;
  // Acquisition modes
  localparam logic [1:0] MODE_POST = 2'h0;
  localparam logic [1:0] MODE_PRE = 2'h1;
  localparam logic [1:0] MODE_ABOUT = 2'h2;
  localparam logic [1:0] MODE_STREAM = 2'h3;
  // Acquisition sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SDLY = 5'h02,
    ST_RUN = 5'h04,
    ST_PDLY = 5'h08,
    ST_DONE = 5'h10
  } dia_state_e;
endpackage

`default_nettype wire

// file: rtl/dia_top.sv
// Function
// - Each channel raises an event on rising, falling or both edges as selected.
// - Edge event enable and edge selection are held separately for every channel.
// - Per port, enabled channels are compared to a pattern; a match raises an event.
// - With filtering on, pulses shorter than the filter duration cause no event.
// - Filter enable is per channel; filter duration is shared by each 8-channel port.
// - An instant-read command captures all channels at once and returns the snapshot.
// - Buffered samples use a sample clock from an internal divider or an external pin.
// - Buffered samples enter an onboard FIFO in order and drain to a DMA port.
// - Post-trigger starts on the start trigger and ends after the programmed count.
// - Post-trigger start is software or hardware; hardware start may be delayed.
// - Pre-trigger starts by software, ends on hardware stop, keeps the last samples.
// - Pre- and about-trigger modes accept only a hardware stop trigger.
// - About-trigger runs on for a programmed number of sample clocks after stop.
// - Streaming has no sample limit and runs from start until a stop trigger.
// - Streaming start and stop are software or hardware; hardware ones may be delayed.
// - With retrigger, the block rearms after an acquisition and restarts on the next start trigger.
// - In retriggerable post-trigger mode, starts during a running acquisition are ignored.
// - In retriggerable about-trigger mode, stops during the post-stop delay are ignored.
// - The hardware trigger comes from one selected channel, on its rising or falling edge.
// - The sample FIFO holds up to 512 entries, each holding every channel.
`timescale 1ns/1ps
`default_nettype none

module dia_fifo
  import dia_pkg::*;
#(
  parameter int W = NCH_DEF,
  parameter int DEPTH = FIFO_DEPTH_DEF,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [AW:0] level
);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Pointer step with wrap for any depth
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == LAST) ? '0 : p + AW'(1);
  endfunction

  // Handshakes; a full FIFO still accepts when a word leaves in the same cycle
  assign out_valid = (cnt_q != '0);
  assign pop = out_valid && out_ready;
  assign in_ready = (cnt_q != FULL) || pop;
  assign push = in_valid && in_ready;
  assign out_data = mem_q[rptr_q];
  assign level = cnt_q;

  // Storage
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_q[wptr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_q <= step(wptr_q);
      end
      if (pop)
      begin
        rptr_q <= step(rptr_q);
      end
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

module dia_top
  import dia_pkg::*;
#(
  parameter int NCH = NCH_DEF,
  parameter int NPORT = NCH / PORT_W,
  parameter int FDW = FDW_DEF,
  parameter int CW = CW_DEF,
  parameter int DEPTH = FIFO_DEPTH_DEF,
  parameter int TW = $clog2(NCH),
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Field inputs
  input wire logic [NCH-1:0] di,
  // Debounce filter
  input wire logic [NCH-1:0] filt_en,
  input wire logic [NPORT*FDW-1:0] filt_dur,
  // Edge events
  input wire logic [NCH-1:0] edge_en,
  input wire logic [NCH-1:0] rise_sel,
  input wire logic [NCH-1:0] fall_sel,
  output logic [NCH-1:0] edge_evt,
  // Pattern match
  input wire logic [NCH-1:0] pm_en,
  input wire logic [NCH-1:0] pm_val,
  output logic [NPORT-1:0] pm_evt,
  // Instant read
  input wire logic rd_cmd,
  output logic rd_valid,
  output logic [NCH-1:0] rd_data,
  // Buffered acquisition control
  input wire logic acq_en,
  input wire logic [1:0] mode,
  input wire logic retrig,
  input wire logic start_hw,
  input wire logic stop_hw,
  input wire logic sw_start,
  input wire logic sw_stop,
  input wire logic [TW-1:0] trig_ch,
  input wire logic trig_fall,
  input wire logic [CW-1:0] start_dly,
  input wire logic [CW-1:0] stop_dly,
  input wire logic [CW-1:0] samp_count,
  // Sample clock
  input wire logic ext_clk_sel,
  input wire logic ext_sclk,
  input wire logic [CW-1:0] sclk_div,
  // Status
  output logic acq_busy,
  output logic acq_done,
  output logic ovf_evt,
  // DMA drain
  output logic dma_valid,
  input wire logic dma_ready,
  output logic [NCH-1:0] dma_data,
  output logic [AW:0] fifo_level
);
  dia_state_e state_q;
  logic [NCH-1:0] di_q;
  logic [NCH-1:0] filt_q;
  logic [NCH-1:0] fprev_q;
  logic [NCH-1:0] edge_q;
  logic [NPORT-1:0] pm_match;
  logic [NPORT-1:0] pm_prev_q;
  logic [NPORT-1:0] pm_q;
  logic [NCH-1:0] rd_data_q;
  logic rd_valid_q;
  logic [CW-1:0] div_q;
  logic ext_prev_q;
  logic trg_prev_q;
  logic [CW-1:0] dly_q;
  logic [CW-1:0] smp_q;
  logic done_q;
  logic ovf_q;
  logic tick;
  logic hw_trig;
  logic start_ev;
  logic stop_ev;
  logic pre_like;
  logic hold;
  logic push_req;
  logic drop;
  logic in_ready;
  logic out_ready;
  logic dly_end;
  logic smp_end;

  // Input register
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      di_q <= '0;
    end
    else
    begin
      di_q <= di;
    end
  end

  // Per-channel debounce, edge events and settings
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    logic [FDW-1:0] cnt_q;
    logic [FDW-1:0] dur;
    assign dur = filt_dur[(i / PORT_W) * FDW +: FDW];
    always_ff @(posedge clock)
    begin
      if (!reset_n)
      begin
        filt_q[i] <= 1'b0;
        cnt_q <= '0;
      end
      else if (!filt_en[i] || di_q[i] == filt_q[i])
      begin
        filt_q[i] <= di_q[i];
        cnt_q <= '0;
      end
      else if ((cnt_q + FDW'(1)) >= dur)
      begin
        filt_q[i] <= di_q[i];
        cnt_q <= '0;
      end
      else
      begin
        cnt_q <= cnt_q + FDW'(1);
      end
    end
    always_ff @(posedge clock)
    begin
      if (!reset_n)
      begin
        fprev_q[i] <= 1'b0;
        edge_q[i] <= 1'b0;
      end
      else
      begin
        fprev_q[i] <= filt_q[i];
        edge_q[i] <= edge_en[i] && ((rise_sel[i] && filt_q[i] && !fprev_q[i]) ||
          (fall_sel[i] && !filt_q[i] && fprev_q[i]));
      end
    end
  end
  assign edge_evt = edge_q;

  // Per-port pattern match; disabled channels are don't-care
  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    assign pm_match[p] = &(~(filt_q[p*PORT_W +: PORT_W] ^ pm_val[p*PORT_W +: PORT_W]) |
      ~pm_en[p*PORT_W +: PORT_W]);
  end
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      pm_prev_q <= '0;
      pm_q <= '0;
    end
    else
    begin
      pm_prev_q <= pm_match;
      pm_q <= pm_match & ~pm_prev_q;
    end
  end
  assign pm_evt = pm_q;

  // Instant snapshot of all channels
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= rd_cmd;
      if (rd_cmd)
      begin
        rd_data_q <= di_q;
      end
    end
  end
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;

  // Sample clock: internal divider or external rising edge
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      div_q <= '0;
      ext_prev_q <= 1'b0;
      trg_prev_q <= 1'b0;
    end
    else
    begin
      div_q <= ((div_q + CW'(1)) >= sclk_div) ? '0 : div_q + CW'(1);
      ext_prev_q <= ext_sclk;
      trg_prev_q <= filt_q[trig_ch];
    end
  end
  assign tick = ext_clk_sel ? (ext_sclk && !ext_prev_q) :
    ((div_q + CW'(1)) >= sclk_div);

  // Hardware trigger from one selected channel, chosen edge
  assign hw_trig = trig_fall ? (trg_prev_q && !filt_q[trig_ch]) :
    (!trg_prev_q && filt_q[trig_ch]);

  // Trigger qualification per mode
  assign pre_like = (mode == MODE_PRE) || (mode == MODE_ABOUT);
  assign start_ev = pre_like ? sw_start : (start_hw ? hw_trig : sw_start);
  assign stop_ev = pre_like ? hw_trig : (stop_hw ? hw_trig : sw_stop);
  assign dly_end = tick && ((dly_q + CW'(1)) >= (state_q == ST_SDLY ? start_dly : stop_dly));
  assign smp_end = (smp_q + CW'(1)) >= samp_count;

  // Acquisition sequencer
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
    end
    else if (!acq_en)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start_ev) // Starts only taken while idle
          begin
            state_q <= (!pre_like && start_hw && start_dly != '0) ? ST_SDLY : ST_RUN;
          end
        end
        ST_SDLY:
        begin
          if (dly_end)
          begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (mode == MODE_POST)
          begin
            if (tick && smp_end)
            begin
              state_q <= ST_DONE;
            end
          end
          else if (stop_ev && mode != MODE_PRE && stop_dly != '0 &&
            (mode == MODE_ABOUT || stop_hw))
          begin
            state_q <= ST_PDLY;
          end
          else if (stop_ev)
          begin
            state_q <= ST_DONE;
          end
        end
        ST_PDLY:
        begin
          if (dly_end)
          begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          if (retrig)
          begin
            state_q <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Delay and sample counters
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      dly_q <= '0;
      smp_q <= '0;
    end
    else
    begin
      if (state_q != ST_SDLY && state_q != ST_PDLY)
      begin
        dly_q <= '0;
      end
      else if (tick)
      begin
        dly_q <= dly_q + CW'(1);
      end
      if (state_q != ST_RUN)
      begin
        smp_q <= '0;
      end
      else if (tick)
      begin
        smp_q <= smp_q + CW'(1);
      end
    end
  end

  // Done and overflow pulses
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      done_q <= 1'b0;
      ovf_q <= 1'b0;
    end
    else
    begin
      done_q <= acq_en && state_q != ST_DONE && state_q != ST_IDLE &&
        ((state_q == ST_RUN && ((mode == MODE_POST && tick && smp_end) ||
        (mode != MODE_POST && stop_ev))) || (state_q == ST_PDLY && dly_end)) &&
        !(state_q == ST_RUN && mode != MODE_POST && mode != MODE_PRE && stop_ev &&
        stop_dly != '0 && (mode == MODE_ABOUT || stop_hw));
      ovf_q <= push_req && !in_ready;
    end
  end
  assign acq_done = done_q;
  assign ovf_evt = ovf_q;
  assign acq_busy = (state_q != ST_IDLE) && (state_q != ST_DONE);

  // Sample path; pre-trigger window trims the oldest sample while running
  assign push_req = tick && (state_q == ST_RUN || state_q == ST_PDLY);
  assign hold = pre_like && acq_busy;
  assign drop = hold && push_req && (fifo_level >= (AW + 1)'(samp_count));
  assign out_ready = hold ? drop : dma_ready;

  dia_fifo #(
    .W(NCH),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(push_req),
    .in_ready(in_ready),
    .in_data(di_q),
    .out_valid(dma_valid),
    .out_ready(out_ready),
    .out_data(dma_data),
    .level(fifo_level)
  );

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_rd_req;
    rd_cmd;
  endsequence
  sequence s_rd_ans;
    rd_valid && rd_data == $past(di_q);
  endsequence
  chk_edge_rise: assert property ($rose(filt_q[0]) && edge_en[0] && rise_sel[0] |=> edge_evt[0])
    else $error("rising edge event missing");
  chk_edge_off: assert property (!edge_en[0] |=> !edge_evt[0])
    else $error("edge event while disabled");
  chk_pm_fire: assert property ($rose(pm_match[0]) |=> pm_evt[0])
    else $error("pattern match event missing");
  chk_filt_glitch: assert property (filt_en[4] && $past(filt_en[4]) && filt_dur[FDW-1:0] == FDW'(4)
    && $changed(filt_q[4]) |-> $past(di_q[4], 4) == filt_q[4] && $past(di_q[4], 2) == filt_q[4])
    else $error("short pulse passed filter");
  chk_snap_read: assert property (s_rd_req |=> s_rd_ans)
    else $error("instant read wrong");
  chk_post_end: assert property (acq_en && state_q == ST_RUN && mode == MODE_POST && tick && smp_end
    |=> state_q == ST_DONE)
    else $error("post-trigger did not end");
  chk_pre_swonly: assert property (acq_en && state_q == ST_IDLE && pre_like && !sw_start
    |=> state_q == ST_IDLE)
    else $error("pre-trigger started without software");
  chk_sdly_end: assert property (acq_en && state_q == ST_SDLY && dly_end |=> state_q == ST_RUN)
    else $error("start delay wrong");
  chk_pdly_hold: assert property (acq_en && state_q == ST_PDLY && !dly_end |=> state_q == ST_PDLY)
    else $error("stop during delay not ignored");
  chk_ovf_drop: assert property (push_req && !in_ready |=> ovf_evt ##0 fifo_level == $past(fifo_level)
    || $past(out_ready && dma_valid))
    else $error("overflow not flagged");
endmodule

`default_nettype wire

// file: tb/dia_far_side.sv
`timescale 1ns/1ps
`default_nettype none

// DMA engine stand-in: slow ready, counts words, also makes the external sample clock
module dia_far_side (
  // Clock and control
  input wire logic clock,
  input wire logic hold,
  // DMA drain
  input wire logic dma_valid,
  input wire logic [15:0] dma_data,
  output logic dma_ready,
  // Sample clock and capture
  output logic ext_sclk,
  output int got_cnt,
  output logic [15:0] got_last
);
  int ph;

  initial
  begin
    dma_ready = 1'b0;
    ext_sclk = 1'b0;
    got_cnt = 0;
    got_last = 16'h0000;
    ph = 0;
  end

  // Take a word at the edge where valid and ready meet
  always @(posedge clock)
    if (dma_valid === 1'b1 && dma_ready)
    begin
      got_cnt <= got_cnt + 1;
      got_last <= dma_data;
    end

  // Ready every other cycle unless stalled; sample clock period of six cycles
  always @(negedge clock)
  begin
    ph <= ph + 1;
    dma_ready <= !hold && ph[0];
    ext_sclk <= (ph % 6) < 3;
  end
endmodule

`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import dia_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] di = '0, filt_en = 16'h0010, edge_en = 16'h0017, rise_sel = 16'h001d;
  logic [15:0] fall_sel = 16'h0006, pm_en = 16'h0f00, pm_val = 16'h0500;
  logic [39:0] filt_dur = 40'h00_0000_0004;
  logic rd_cmd = 0, acq_en = 0, retrig = 0, start_hw = 0, stop_hw = 0, sw_start = 0, sw_stop = 0;
  logic trig_fall = 0, ext_clk_sel = 0, hold = 0;
  logic [1:0] mode = MODE_POST;
  logic [3:0] trig_ch = 4'h0;
  logic [15:0] start_dly = '0, stop_dly = '0, samp_count = 16'h0003, sclk_div = 16'h0002;
  logic [15:0] edge_evt, rd_data, dma_data, got_last, ev_seen;
  logic [1:0] pm_evt, pm_seen;
  logic rd_valid, acq_busy, acq_done, ovf_evt, dma_valid, dma_ready, ext_sclk;
  logic done_seen, ovf_seen;
  logic [3:0] fifo_level;
  int got_cnt, base, err_total = 0, checks_done = 0;

  // Clock at 10 MHz
  always #50 clock = ~clock;

  dia_top #(.DEPTH(8)) dut (.clock(clock), .reset_n(reset_n), .di(di), .filt_en(filt_en),
    .filt_dur(filt_dur), .edge_en(edge_en), .rise_sel(rise_sel), .fall_sel(fall_sel),
    .edge_evt(edge_evt), .pm_en(pm_en), .pm_val(pm_val), .pm_evt(pm_evt), .rd_cmd(rd_cmd),
    .rd_valid(rd_valid), .rd_data(rd_data), .acq_en(acq_en), .mode(mode), .retrig(retrig),
    .start_hw(start_hw), .stop_hw(stop_hw), .sw_start(sw_start), .sw_stop(sw_stop),
    .trig_ch(trig_ch), .trig_fall(trig_fall), .start_dly(start_dly), .stop_dly(stop_dly),
    .samp_count(samp_count), .ext_clk_sel(ext_clk_sel), .ext_sclk(ext_sclk),
    .sclk_div(sclk_div), .acq_busy(acq_busy), .acq_done(acq_done), .ovf_evt(ovf_evt),
    .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_data(dma_data),
    .fifo_level(fifo_level));

  dia_far_side far (.clock(clock), .hold(hold), .dma_valid(dma_valid), .dma_data(dma_data),
    .dma_ready(dma_ready), .ext_sclk(ext_sclk), .got_cnt(got_cnt), .got_last(got_last));

  // Collect one-cycle event pulses
  always @(posedge clock)
  begin
    ev_seen <= ev_seen | edge_evt;
    pm_seen <= pm_seen | pm_evt;
    done_seen <= done_seen | acq_done;
    ovf_seen <= ovf_seen | ovf_evt;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic clr_seen();
    ev_seen <= '0;
    pm_seen <= '0;
    done_seen <= 0;
    ovf_seen <= 0;
  endtask

  task automatic pulse_start();
    sw_start = 1;
    cyc(1);
    sw_start = 0;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 400 && acq_busy !== 1'b0; i++) cyc(1);
    if (acq_busy !== 1'b0)
    begin
      $display("[FAIL] acq_busy expected 0 seen %b", acq_busy);
      err_total++;
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Snapshot of all channels one cycle after the command
  task automatic t_instant();
    di = 16'ha5c3;
    cyc(3);
    rd_cmd = 1;
    cyc(1);
    rd_cmd = 0;
    chk("rd_valid", 16'h0001, {15'h0, rd_valid});
    chk("rd_data", 16'ha5c3, rd_data);
    cyc(1);
    chk("rd_valid low", 16'h0000, {15'h0, rd_valid});
    di = '0;
    cyc(30);
  endtask

  // Edge selection per channel, glitch on filtered channel
  task automatic t_edges();
    clr_seen();
    cyc(1);
    di[4:0] = 5'h1f;
    cyc(2);
    di[4:0] = 5'h00;
    cyc(12);
    chk("edge short", 16'h0007, ev_seen);
    clr_seen();
    di[4] = 1;
    cyc(8);
    di[4] = 0;
    cyc(12);
    chk("edge long", 16'h0010, ev_seen);
  endtask

  // Port pattern with don't-care channels
  task automatic t_pattern();
    di[15:8] = 8'h04;
    cyc(4);
    clr_seen();
    cyc(4);
    chk("pm miss", 16'h0000, {14'h0, pm_seen});
    di[15:8] = 8'hf5;
    cyc(4);
    chk("pm hit", 16'h0002, {14'h0, pm_seen});
  endtask

  // Post-trigger on external sample clock with retrigger
  task automatic t_post();
    di = 16'h3c3c;
    mode = MODE_POST;
    ext_clk_sel = 1;
    retrig = 1;
    base = got_cnt;
    clr_seen();
    pulse_start();
    cyc(3);
    pulse_start();
    wait_idle();
    cyc(40);
    chk("post count", 16'd3, 16'(got_cnt - base));
    chk("post data", 16'h3c3c, got_last);
    chk("post done", 16'h0001, {15'h0, done_seen});
    pulse_start();
    wait_idle();
    cyc(40);
    chk("retrig count", 16'd6, 16'(got_cnt - base));
    retrig = 0;
  endtask

  // Unbounded stream into a stalled sink until overflow
  task automatic t_stream();
    acq_en = 0;
    cyc(1);
    acq_en = 1;
    mode = MODE_STREAM;
    ext_clk_sel = 0;
    hold = 1;
    clr_seen();
    cyc(1);
    pulse_start();
    cyc(60);
    chk("stream busy", 16'h0001, {15'h0, acq_busy});
    chk("fifo full", 16'h0008, {12'h0, fifo_level});
    chk("overflow", 16'h0001, {15'h0, ovf_seen});
    sw_stop = 1;
    cyc(1);
    sw_stop = 0;
    wait_idle();
    base = got_cnt;
    hold = 0;
    cyc(40);
    chk("drained", 16'd8, 16'(got_cnt - base));
    chk("fifo empty", 16'h0000, {12'h0, fifo_level});
  endtask

  // Pre-trigger, stop only from rising edge on the trigger channel
  task automatic t_pre();
    di[5] = 0;
    trig_ch = 4'h5;
    acq_en = 0;
    cyc(3);
    acq_en = 1;
    mode = MODE_PRE;
    sclk_div = 16'h0003;
    stop_hw = 1;
    hold = 1;
    pulse_start();
    cyc(40);
    sw_stop = 1;
    cyc(1);
    sw_stop = 0;
    cyc(4);
    chk("pre sw stop", 16'h0001, {15'h0, acq_busy});
    di[5] = 1;
    wait_idle();
    chk("pre kept", 16'h0003, {12'h0, fifo_level});
    base = got_cnt;
    hold = 0;
    cyc(30);
    chk("pre drained", 16'd3, 16'(got_cnt - base));
  endtask

  // About-trigger on a falling edge; a second stop inside the delay is ignored
  task automatic t_about();
    acq_en = 0;
    cyc(1);
    acq_en = 1;
    mode = MODE_ABOUT;
    stop_dly = 16'h0002;
    trig_fall = 1;
    hold = 1;
    pulse_start();
    cyc(30);
    di[5] = 0;
    cyc(1);
    di[5] = 1;
    cyc(1);
    di[5] = 0;
    di[0] = 1;
    cyc(2);
    chk("about busy", 16'h0001, {15'h0, acq_busy});
    wait_idle();
    chk("about kept", 16'h0003, {12'h0, fifo_level});
    hold = 0;
    cyc(30);
    chk("about last", 16'h3c1d, got_last);
  endtask

  // Hardware start on a rising edge, first sample held off by the start delay
  task automatic t_hw_start();
    acq_en = 0;
    cyc(1);
    acq_en = 1;
    mode = MODE_POST;
    start_hw = 1;
    start_dly = 16'h0002;
    trig_fall = 0;
    hold = 1;
    base = got_cnt;
    cyc(2);
    di[5] = 1;
    cyc(6);
    chk("start delay busy", 16'h0001, {15'h0, acq_busy});
    chk("start delay level", 16'h0000, {12'h0, fifo_level});
    wait_idle();
    hold = 0;
    cyc(30);
    chk("hw start count", 16'd3, 16'(got_cnt - base));
  endtask

  // Main sequence
  initial
  begin
    cyc(6);
    reset_n = 1;
    acq_en = 1;
    cyc(2);
    t_instant();
    t_edges();
    t_pattern();
    t_post();
    t_stream();
    t_pre();
    t_about();
    t_hw_start();
    print_verdict();
  end

  // Watchdog well past the expected run length
  initial
  begin
    #2_000_000;
    err_total++;
    print_verdict();
  end
endmodule

`default_nettype wire
